// File: common/lcd_port_pkg.sv
// Shared constants for the display host bus port
package lcd_port_pkg;
  localparam int BYTE_W = 8;
  localparam int NIB_W = 4;
  localparam int ADDR_W = 7;
  localparam int FIFO_DEPTH = 16;
  // Pin bundle layout after synchronisation: {sel, dir, strobe, data}
  localparam int PIN_W = BYTE_W + 3;
  localparam int PIN_RS = BYTE_W + 2;
  localparam int PIN_RW = BYTE_W + 1;
  localparam int PIN_EN = BYTE_W;
  // Queue word: {is_data, byte}
  localparam int CMD_W = BYTE_W + 1;
  // Function-set decode: top three bits 001, width bit at position 4
  localparam int FS_TOP = 7;
  localparam int FS_LOW = 5;
  localparam logic [2:0] FS_CODE = 3'h1;
  localparam int DL_POS = 4;
  localparam logic WIDE_RESET = 1'h1;
endpackage

// File: common/fifo_link_if.sv
// Valid/ready carrier between the port logic and its command queue
`timescale 1ns/1ns
`default_nettype none
interface fifo_link_if #(parameter int W = 9);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fill (output in_valid, output in_data, input in_ready, input out_valid, input out_data, output out_ready);
  modport queue (input in_valid, input in_data, output in_ready, output out_valid, output out_data, input out_ready);
endinterface
`default_nettype wire

// File: rtl/cmd_fifo.sv
// Synchronous FIFO with registered head word
`timescale 1ns/1ns
`default_nettype none
module cmd_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  fifo_link_if.queue link
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = DEPTH[PW:0];
  localparam logic [PW:0] ONE_C = {{PW{1'b0}}, 1'b1};

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW-1:0] rd_d;
  logic [PW:0] cnt_q;
  logic [W-1:0] head_q;
  logic push;
  logic pop;

  // Honest full/empty from the occupancy count
  assign link.in_ready = (cnt_q != DEPTH_C);
  assign link.out_valid = (cnt_q != '0);
  assign link.out_data = head_q;
  assign push = link.in_valid & link.in_ready;
  assign pop = link.out_valid & link.out_ready;
  assign rd_d = pop ? rd_q + 1'b1 : rd_q;

  // Storage array, no reset needed
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_q[wr_q] <= link.in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      rd_q <= rd_d;
      if (push && !pop) begin
        cnt_q <= cnt_q + ONE_C;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - ONE_C;
      end
    end
  end

  // Head register; bypass covers a write into the slot about to become head
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      head_q <= '0;
    end else if (ce) begin
      if (push && wr_q == rd_d) begin
        head_q <= link.in_data;
      end else begin
        head_q <= mem_q[rd_d];
      end
    end
  end
endmodule // cmd_fifo
`default_nettype wire

// File: rtl/lcd_host_port.sv
// Host-facing parallel bus port of a character display controller
`timescale 1ns/1ns
`default_nettype none
module lcd_host_port #(
  parameter int DEPTH = lcd_port_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic rs_pin,
  input wire logic rw_pin,
  input wire logic en_pin,
  input wire logic [lcd_port_pkg::BYTE_W-1:0] data_in,
  output logic [lcd_port_pkg::BYTE_W-1:0] data_out,
  output logic [lcd_port_pkg::BYTE_W-1:0] data_oe,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic cmd_is_data,
  output logic [lcd_port_pkg::BYTE_W-1:0] cmd_byte,
  input wire logic core_idle,
  input wire logic [lcd_port_pkg::ADDR_W-1:0] addr_count,
  input wire logic [lcd_port_pkg::BYTE_W-1:0] read_data,
  output logic internal_operation_flag,
  output logic bus_width_select_bit
);
  localparam int BW = lcd_port_pkg::BYTE_W;
  localparam int NW = lcd_port_pkg::NIB_W;
  localparam int PW = lcd_port_pkg::PIN_W;

  fifo_link_if #(.W(lcd_port_pkg::CMD_W)) link ();

  logic [PW-1:0] s1_q;
  logic [PW-1:0] s2_q;
  logic [PW-1:0] s3_q;
  logic [PW-1:0] filt_q;
  logic en_prev_q;
  logic phase_q;
  logic [NW-1:0] upper_q;
  logic [BW-1:0] rd_hold_q;
  logic [BW-1:0] data_out_q;
  logic busy_q;
  logic wide_q;
  logic rs_f;
  logic rw_f;
  logic en_f;
  logic [BW-1:0] data_f;
  logic wr_strobe;
  logic rd_strobe;
  logic commit;
  logic [BW-1:0] byte_d;
  logic [BW-1:0] rd_sel;
  logic drive;

  // True when a completed byte is a function-set instruction
  function automatic logic is_func_set(input logic sel, input logic [BW-1:0] b);
    is_func_set = !sel && (b[lcd_port_pkg::FS_TOP:lcd_port_pkg::FS_LOW] == lcd_port_pkg::FS_CODE);
  endfunction

  // Three-stage pin synchroniser; only s2/s3 are compared, never s1
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce) begin
      s1_q <= {rs_pin, rw_pin, en_pin, data_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit changes only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      filt_q <= '0;
      en_prev_q <= 1'b0;
    end else if (ce) begin
      filt_q <= (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & filt_q);
      en_prev_q <= filt_q[lcd_port_pkg::PIN_EN];
    end
  end

  assign rs_f = filt_q[lcd_port_pkg::PIN_RS];
  assign rw_f = filt_q[lcd_port_pkg::PIN_RW];
  assign en_f = filt_q[lcd_port_pkg::PIN_EN];
  assign data_f = filt_q[BW-1:0];
  // Writes latch on the falling strobe, reads launch on the rising one
  assign wr_strobe = en_prev_q & ~en_f & ~rw_f;
  assign rd_strobe = ~en_prev_q & en_f & rw_f;
  assign rd_sel = rs_f ? read_data : {busy_q, addr_count};

  // A byte is complete on one strobe when wide, on the second when narrow
  always_comb begin
    commit = 1'b0;
    byte_d = data_f;
    if (wr_strobe) begin
      if (wide_q) begin
        commit = 1'b1;
      end else if (phase_q) begin
        commit = 1'b1;
        byte_d = {upper_q, data_f[BW-1:NW]};
      end
    end
  end

  // Queue push; a full queue holds busy high so a polite host waits
  assign link.in_valid = commit;
  assign link.in_data = {rs_f, byte_d};
  assign link.out_ready = cmd_ready;
  assign cmd_valid = link.out_valid;
  assign {cmd_is_data, cmd_byte} = link.out_data;

  // Nibble phase shared by reads and writes; upper nibble kept for assembly
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_q <= 1'b0;
      upper_q <= '0;
    end else if (ce && !wide_q && (wr_strobe || rd_strobe)) begin
      phase_q <= ~phase_q;
      if (wr_strobe && !phase_q) begin
        upper_q <= data_f[BW-1:NW];
      end
    end
  end

  // Read data: whole byte when wide, upper then lower nibble when narrow
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_out_q <= '0;
      rd_hold_q <= '0;
    end else if (ce && rd_strobe) begin
      if (wide_q) begin
        data_out_q <= rd_sel;
      end else if (!phase_q) begin
        rd_hold_q <= rd_sel; // Snapshot so both halves come from one value
        data_out_q <= {rd_sel[BW-1:NW], {NW{1'b0}}};
      end else begin
        data_out_q <= {rd_hold_q[NW-1:0], {NW{1'b0}}};
      end
    end
  end

  // Drive only while the host holds a read strobe; lower lines only when wide
  assign drive = en_f & rw_f;
  assign data_oe = {{NW{drive}}, {NW{drive & wide_q}}};
  assign data_out = data_out_q;

  // Busy: set by a completed byte, set wins over the idle clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (ce) begin
      if (commit || !link.in_ready) begin
        busy_q <= 1'b1;
      end else if (core_idle && !link.out_valid) begin
        busy_q <= 1'b0;
      end
    end
  end
  assign internal_operation_flag = busy_q;

  // Bus width follows the function-set width bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wide_q <= lcd_port_pkg::WIDE_RESET;
    end else if (ce && commit && link.in_ready && is_func_set(rs_f, byte_d)) begin
      wide_q <= byte_d[lcd_port_pkg::DL_POS];
    end
  end
  assign bus_width_select_bit = wide_q;

  cmd_fifo #(.W(lcd_port_pkg::CMD_W), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .link(link)
  );

  property p_wide_byte;
    @(posedge clk) disable iff (!rst_n) wr_strobe && wide_q |-> commit && link.in_data[BW-1:0] == data_f;
  endproperty
  a_wide_byte: assert property (p_wide_byte) else $error("wide write not one transfer");

  property p_low_idle;
    @(posedge clk) disable iff (!rst_n) !wide_q |-> data_oe[NW-1:0] == '0;
  endproperty
  a_low_idle: assert property (p_low_idle) else $error("lower lines driven in narrow mode");

  // Second narrow strobe: kept nibble on top, current upper lines below
  property p_nib_order;
    @(posedge clk) disable iff (!rst_n)
      ce && wr_strobe && !wide_q && phase_q
      |-> commit && link.in_data[BW-1:NW] == upper_q && link.in_data[NW-1:0] == data_f[BW-1:NW];
  endproperty
  a_nib_order: assert property (p_nib_order) else $error("upper nibble not first");

  property p_busy_late;
    @(posedge clk) disable iff (!rst_n)
      ce && wr_strobe && !wide_q && !phase_q && !busy_q && link.in_ready |=> !busy_q && phase_q;
  endproperty
  a_busy_late: assert property (p_busy_late) else $error("busy rose after first nibble");

  property p_width_sel;
    @(posedge clk) disable iff (!rst_n)
      ce && commit && link.in_ready && is_func_set(rs_f, byte_d) |=> busy_q && wide_q == $past(byte_d[lcd_port_pkg::DL_POS]);
  endproperty
  a_width_sel: assert property (p_width_sel) else $error("width bit not applied");

  property p_read_low;
    @(posedge clk) disable iff (!rst_n)
      ce && rd_strobe && !wide_q && phase_q |=> data_out[BW-1:NW] == $past(rd_hold_q[NW-1:0]) && !phase_q;
  endproperty
  a_read_low: assert property (p_read_low) else $error("second read nibble wrong");

  c_wide_write: cover property (@(posedge clk) disable iff (!rst_n) wr_strobe && wide_q);
  c_narrow_byte: cover property (@(posedge clk) disable iff (!rst_n) commit && !wide_q);
  c_narrow_read: cover property (@(posedge clk) disable iff (!rst_n) rd_strobe && !wide_q && phase_q);
  c_queue_full: cover property (@(posedge clk) disable iff (!rst_n) !link.in_ready);
endmodule // lcd_host_port
`default_nettype wire

// File: sim/host_bus_model.sv
// Behavioural host processor that drives the display port pins
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
  input wire logic clk,
  input wire logic [7:0] data_out,
  output logic rs_pin,
  output logic rw_pin,
  output logic en_pin,
  output logic [7:0] data_in
);
  // Idle bus: strobe low, write direction
  initial begin
    rs_pin = 1'h0;
    rw_pin = 1'h0;
    en_pin = 1'h0;
    data_in = 8'h00;
  end

  // One strobe; 6 clocks of setup and hold clear the 4-clock pin filter
  task automatic strobe(input logic rs, input logic rw, input logic [7:0] lines, output logic [7:0] got);
    @(posedge clk);
    rs_pin <= rs;
    rw_pin <= rw;
    data_in <= lines;
    repeat (6) @(posedge clk);
    en_pin <= 1'h1;
    repeat (10) @(posedge clk);
    got = data_out;
    en_pin <= 1'h0;
    repeat (6) @(posedge clk);
    rw_pin <= 1'h0;
    data_in <= ~lines; // Released lines must not keep the old value
  endtask

  // Lower lines carry the inverse nibble in narrow mode so they cannot help
  task automatic wr(input logic rs, input logic [7:0] b, input logic wide);
    logic [7:0] g;
    if (wide) begin
      strobe(rs, 1'h0, b, g);
    end else begin
      strobe(rs, 1'h0, {b[7:4], ~b[7:4]}, g);
      strobe(rs, 1'h0, {b[3:0], ~b[3:0]}, g);
    end
  endtask

  // Narrow reads take the upper nibble first, then the lower one
  task automatic rd(input logic rs, input logic wide, output logic [7:0] b);
    logic [7:0] g;
    strobe(rs, 1'h1, 8'h00, b);
    if (!wide) begin
      strobe(rs, 1'h1, 8'h00, g);
      b = {b[7:4], g[7:4]};
    end
  endtask

  // Poll status until busy reads 0, giving up after 20 polls
  task automatic wait_ready(input logic wide, output logic ok);
    logic [7:0] s;
    ok = 1'h0;
    for (int i = 0; i < 20 && !ok; i++) begin
      rd(1'h0, wide, s);
      ok = !s[7];
    end
  endtask
endmodule // host_bus_model
`default_nettype wire

// File: sim/lcd_host_bus_width_port_tb_top.sv
// Self-checking testbench for the display host bus port
`timescale 1ns/1ns
`default_nettype none
module lcd_host_bus_width_port_tb_top;
  logic clk = 1'h0;
  logic rst_n;
  logic rs_pin, rw_pin, en_pin, cmd_ready, core_idle, cmd_valid, cmd_is_data, busy, mode, ok, ce;
  logic [7:0] data_in, data_out, read_data, cmd_byte, b, data_oe, oe_seen;
  logic [6:0] addr_count;
  int miscompares = 0;
  int cmp_count = 0;

  always #10 clk = ~clk;

  // Last enable pattern seen while the host holds a read strobe
  always @(posedge clk) if (en_pin === 1'h1 && rw_pin === 1'h1) oe_seen <= data_oe;

  host_bus_model host (.clk(clk), .data_out(data_out), .rs_pin(rs_pin), .rw_pin(rw_pin), .en_pin(en_pin),
    .data_in(data_in));

  lcd_host_port dut (.clk(clk), .rst_n(rst_n), .ce(ce), .rs_pin(rs_pin), .rw_pin(rw_pin), .en_pin(en_pin),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_is_data(cmd_is_data), .cmd_byte(cmd_byte), .core_idle(core_idle), .addr_count(addr_count),
    .read_data(read_data), .internal_operation_flag(busy), .bus_width_select_bit(mode));

  task automatic conclude();
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  // Waits for a queue head under a bound, compares it, then pops it
  task automatic pop(input logic [8:0] exp);
    int n;
    n = 0;
    while (cmd_valid !== 1'h1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (n == 60) begin
      miscompares++;
      conclude();
    end
    check("cmd", exp, {cmd_is_data, cmd_byte});
    @(posedge clk);
    cmd_ready <= 1'h1;
    @(posedge clk);
    cmd_ready <= 1'h0;
    @(negedge clk);
  endtask

  // Core held busy until the head is popped, so busy must survive the pop
  task automatic t_wide();
    host.wr(1'h1, 8'hA5, 1'h1);
    core_idle <= 1'h0;
    @(negedge clk);
    check("busy", 9'h001, {8'h00, busy});
    pop({1'h1, 8'hA5});
    check("busy", 9'h001, {8'h00, busy});
    @(posedge clk);
    core_idle <= 1'h1;
    host.wait_ready(1'h1, ok);
    check("ready", 9'h001, {8'h00, ok});
    if (ok !== 1'h1) conclude();
    host.rd(1'h1, 1'h1, b);
    @(negedge clk);
    check("rdata", 9'h096, {1'h0, b});
    check("oe_wide", 9'h0FF, {1'h0, oe_seen});
    check("oe_idle", 9'h000, {1'h0, data_oe});
  endtask

  task automatic t_narrow();
    host.wr(1'h0, 8'h2C, 1'h1);
    pop({1'h0, 8'h2C});
    check("mode", 9'h000, {8'h00, mode});
    host.strobe(1'h1, 1'h0, 8'hC3, b);
    @(negedge clk);
    check("busy1", 9'h000, {8'h00, busy});
    host.strobe(1'h1, 1'h0, 8'h3C, b);
    @(negedge clk);
    check("busy2", 9'h001, {8'h00, busy});
    pop({1'h1, 8'hC3});
    host.wait_ready(1'h0, ok);
    check("ready", 9'h001, {8'h00, ok});
    if (ok !== 1'h1) conclude();
    host.rd(1'h0, 1'h0, b);
    check("status", 9'h05A, {1'h0, b});
    host.rd(1'h1, 1'h0, b);
    check("nrdata", 9'h096, {1'h0, b});
    check("oe_narrow", 9'h0F0, {1'h0, oe_seen});
    host.wr(1'h0, 8'h30, 1'h0);
    pop({1'h0, 8'h30});
    check("mode", 9'h001, {8'h00, mode});
  endtask

  // A write made while the clock enable is low must leave no trace
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'h0;
    host.wr(1'h1, 8'h77, 1'h1);
    @(negedge clk);
    check("frozen", 9'h000, {7'h00, cmd_valid, busy});
    @(posedge clk);
    ce <= 1'h1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("dropped", 9'h000, {7'h00, cmd_valid, busy});
  endtask

  // Fill past the 16-word depth with the consumer stalled; the extra write is dropped
  task automatic t_fill();
    for (int i = 0; i < 17; i++) host.wr(1'h1, 8'(i), 1'h1);
    @(negedge clk);
    check("busyfull", 9'h001, {8'h00, busy});
    for (int i = 0; i < 16; i++) pop({1'h1, 8'(i)});
    check("empty", 9'h000, {8'h00, cmd_valid});
  endtask

  initial begin
    rst_n = 1'h0;
    ce = 1'h1;
    cmd_ready = 1'h0;
    core_idle = 1'h1;
    addr_count = 7'h5A;
    read_data = 8'h96;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    check("mode0", 9'h001, {8'h00, mode});
    check("busy0", 9'h000, {8'h00, busy});
    t_wide();
    t_narrow();
    t_fill();
    t_freeze();
    conclude();
  end
endmodule // lcd_host_bus_width_port_tb_top
`default_nettype wire
